// ---- src/shared_port_pins.v ----
`timescale 1ns/1ps
`default_nettype none
`include "shared_port_pins_regs.vh"
module shared_port_pins #(
  parameter WIDTH = 8,
  parameter PWM_CH = `PWM_CHANNELS
) (
  input wire clk,
  input wire reset,
  input wire clkEnable,
  // CAN controllers side (tx from same-clock logic)
  input wire [2:0] canTxFromCtrl,
  output reg [2:0] canRxToCtrl,
  input wire [2:0] canRxPinIn,
  output reg [2:0] canTxPinOut,
  // two-wire bus port
  input wire twEnable,
  input wire twSclDriveLow,
  input wire twSdaDriveLow,
  output reg twSclIn,
  output reg twSdaIn,
  input wire [WIDTH-1:0] twDirWrData,
  input wire twDirWrite,
  input wire twPullDriveWrite,
  input wire twPullupWrData,
  input wire twReducedWrData,
  input wire [WIDTH-1:0] twDataOut,
  output reg [WIDTH-1:0] twDataIn,
  output reg [WIDTH-1:0] twportDirection,
  output reg twPullupEnable,
  output reg twReducedDrive,
  input wire [WIDTH-1:0] twPinIn,
  output reg [WIDTH-1:0] twPinOut,
  output reg [WIDTH-1:0] twPinOe,
  output reg [WIDTH-1:0] twPinPullup,
  // analog ports
  input wire convAPowerUp,
  input wire convBPowerUp,
  input wire [WIDTH-1:0] analogAPinIn,
  input wire [WIDTH-1:0] analogBPinIn,
  output reg [WIDTH-1:0] analogADataIn,
  output reg [WIDTH-1:0] analogBDataIn,
  // pwm port
  input wire [PWM_CH-1:0] pwmChannelEnable,
  input wire [PWM_CH-1:0] pwmChannelOut,
  input wire [PWM_CH-1:0] pwmDirWrData,
  input wire pwmDirWrite,
  input wire pwmCtrlWrite,
  input wire pwmPullupWrData,
  input wire pwmReducedWrData,
  input wire [PWM_CH-1:0] pwmDataOut,
  output reg [PWM_CH-1:0] pwmDataIn,
  output reg [PWM_CH-1:0] pwmportDirection,
  output reg pwmPullupEnable,
  output reg pwmReducedDrive,
  input wire [PWM_CH-1:0] pwmPinIn,
  output reg [PWM_CH-1:0] pwmPinOut,
  output reg [PWM_CH-1:0] pwmPinOe,
  output reg [PWM_CH-1:0] pwmPinPullup,
  // serial port
  input wire [WIDTH-1:0] serFuncEnable,
  input wire [WIDTH-1:0] serFuncOut,
  input wire [WIDTH-1:0] serFuncOe,
  output reg [WIDTH-1:0] serFuncIn,
  input wire serialLowWireOr,
  input wire spiWireOr,
  input wire serialReducedDrive,
  input wire serialPullupEnable,
  input wire [WIDTH-1:0] serDir,
  input wire [WIDTH-1:0] serDataOut,
  output reg [WIDTH-1:0] serDataIn,
  input wire [WIDTH-1:0] serPinIn,
  output reg [WIDTH-1:0] serPinOut,
  output reg [WIDTH-1:0] serPinOe,
  output reg [WIDTH-1:0] serPinHighSideOff,
  output reg [WIDTH-1:0] serPinPullup,
  output reg serPinReduced,
  // timer port
  input wire timerFunctionEnable,
  input wire pulseAccumEnable,
  input wire [WIDTH-1:0] timerFuncOut,
  input wire [WIDTH-1:0] timerFuncOe,
  output reg [WIDTH-1:0] timerFuncIn,
  input wire [WIDTH-1:0] timerDirWrData,
  input wire timerDirWrite,
  input wire timerMaskWrite,
  input wire timerPullupWrData,
  input wire timerReducedWrData,
  input wire [WIDTH-1:0] timerDataOut,
  output reg [WIDTH-1:0] timerDataIn,
  output reg [WIDTH-1:0] timerportDirection,
  output reg timerPullupEnable,
  output reg timerReducedDrive,
  input wire [WIDTH-1:0] timerPinIn,
  output reg [WIDTH-1:0] timerPinOut,
  output reg [WIDTH-1:0] timerPinOe,
  output reg [WIDTH-1:0] timerPinPullup
);
  // two-stage synchronisers for all pin inputs
  reg [2:0] canRxMeta;
  reg [WIDTH-1:0] twMeta;
  reg [WIDTH-1:0] twSync;
  reg [WIDTH-1:0] anAMeta;
  reg [WIDTH-1:0] anASync;
  reg [WIDTH-1:0] anBMeta;
  reg [WIDTH-1:0] anBSync;
  reg [WIDTH-1:0] serMeta;
  reg [WIDTH-1:0] serSync;
  reg [WIDTH-1:0] tmMeta;
  reg [WIDTH-1:0] tmSync;
  reg [PWM_CH-1:0] pwmMeta;
  reg [PWM_CH-1:0] pwmSync;
  wire timerOwned;
  wire [WIDTH-1:0] twPeriphMask;
  reg [WIDTH-1:0] next_twPinOut;
  reg [WIDTH-1:0] next_twPinOe;
  wire [WIDTH-1:0] next_serPinOut;
  wire [WIDTH-1:0] next_serPinOe;
  wire [WIDTH-1:0] next_serPinPullup;
  wire [WIDTH-1:0] next_timerPinOut;
  wire [WIDTH-1:0] next_timerPinOe;
  wire [PWM_CH-1:0] next_pwmPinOut;
  wire [PWM_CH-1:0] next_pwmPinOe;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      canRxMeta <= {3{`CAN_RECESSIVE}};
      canRxToCtrl <= {3{`CAN_RECESSIVE}};
      twMeta <= `PORT_BYTE_RESET;
      twSync <= `PORT_BYTE_RESET;
      anAMeta <= `PORT_BYTE_RESET;
      anASync <= `PORT_BYTE_RESET;
      anBMeta <= `PORT_BYTE_RESET;
      anBSync <= `PORT_BYTE_RESET;
      serMeta <= `PORT_BYTE_RESET;
      serSync <= `PORT_BYTE_RESET;
      tmMeta <= `PORT_BYTE_RESET;
      tmSync <= `PORT_BYTE_RESET;
      pwmMeta <= `PWM_RESET;
      pwmSync <= `PWM_RESET;
    end else if (clkEnable) begin
      canRxMeta <= canRxPinIn;
      canRxToCtrl <= canRxMeta;
      twMeta <= twPinIn;
      twSync <= twMeta;
      anAMeta <= analogAPinIn;
      anASync <= anAMeta;
      anBMeta <= analogBPinIn;
      anBSync <= anBMeta;
      serMeta <= serPinIn;
      serSync <= serMeta;
      tmMeta <= timerPinIn;
      tmSync <= tmMeta;
      pwmMeta <= pwmPinIn;
      pwmSync <= pwmMeta;
    end
  end

  // control registers
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      twportDirection <= `PORT_BYTE_RESET;
      twPullupEnable <= `CTRL_BIT_RESET;
      twReducedDrive <= `CTRL_BIT_RESET;
      pwmportDirection <= `PWM_RESET;
      pwmPullupEnable <= `CTRL_BIT_RESET;
      pwmReducedDrive <= `CTRL_BIT_RESET;
      timerportDirection <= `PORT_BYTE_RESET;
      timerPullupEnable <= `CTRL_BIT_RESET;
      timerReducedDrive <= `CTRL_BIT_RESET;
    end else if (clkEnable) begin
      if (twDirWrite)
        twportDirection <= twDirWrData;
      if (pwmDirWrite)
        pwmportDirection <= pwmDirWrData;
      if (timerDirWrite)
        timerportDirection <= timerDirWrData;

      if (twPullDriveWrite) begin
        twPullupEnable <= twPullupWrData;
        twReducedDrive <= twReducedWrData;
      end
      if (pwmCtrlWrite) begin
        pwmPullupEnable <= pwmPullupWrData;
        pwmReducedDrive <= pwmReducedWrData;
      end

      if (timerMaskWrite) begin
        timerPullupEnable <= timerPullupWrData;
        timerReducedDrive <= timerReducedWrData;
      end
    end
  end

  assign timerOwned = timerFunctionEnable | pulseAccumEnable;
  // bus owns bits 7 and 6
  assign twPeriphMask = twEnable ?
    ((`TW_LSB_ONE << `TW_SCL_BIT) | (`TW_LSB_ONE << `TW_SDA_BIT)) : `PORT_BYTE_RESET;

  genvar p;
  generate
    for (p = 0; p < PWM_CH; p = p + 1) begin : g_pwmPin
      assign next_pwmPinOut[p] = pwmChannelEnable[p] ? pwmChannelOut[p] : pwmDataOut[p];
      assign next_pwmPinOe[p] = pwmChannelEnable[p] | pwmportDirection[p];
    end
  endgenerate

  genvar s;
  generate
    for (s = 0; s < WIDTH; s = s + 1) begin : g_serPin
      assign next_serPinOut[s] = serFuncEnable[s] ? serFuncOut[s] : serDataOut[s];
      assign next_serPinOe[s] = serFuncEnable[s] ? serFuncOe[s] : serDir[s];
      assign next_serPinPullup[s] = ~serFuncEnable[s] & ~serDir[s] & serialPullupEnable;
    end
  endgenerate

  genvar t;
  generate
    for (t = 0; t < WIDTH; t = t + 1) begin : g_timerPin
      assign next_timerPinOut[t] = timerOwned ? timerFuncOut[t] : timerDataOut[t];
      assign next_timerPinOe[t] = timerOwned ? timerFuncOe[t] : timerportDirection[t];
    end
  endgenerate

  always @* begin
    next_twPinOut = `PORT_BYTE_RESET;
    next_twPinOe = (twportDirection & ~twDataOut & ~twPeriphMask);
    next_twPinOe[`TW_SCL_BIT] = twEnable ? twSclDriveLow :
      (twportDirection[`TW_SCL_BIT] & ~twDataOut[`TW_SCL_BIT]);
    next_twPinOe[`TW_SDA_BIT] = twEnable ? twSdaDriveLow :
      (twportDirection[`TW_SDA_BIT] & ~twDataOut[`TW_SDA_BIT]);
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      canTxPinOut <= {3{`CAN_RECESSIVE}};
      twPinOut <= `PORT_BYTE_RESET;
      twPinOe <= `PORT_BYTE_RESET;
      twPinPullup <= `TW_ALWAYS_PU_MASK;
      twSclIn <= `TW_LINE_IDLE;
      twSdaIn <= `TW_LINE_IDLE;
      twDataIn <= `PORT_BYTE_RESET;
      analogADataIn <= `PORT_BYTE_RESET;
      analogBDataIn <= `PORT_BYTE_RESET;
      pwmPinOut <= `PWM_RESET;
      pwmPinOe <= `PWM_RESET;
      pwmPinPullup <= `PWM_RESET;
      pwmDataIn <= `PWM_RESET;
      serPinOut <= `PORT_BYTE_RESET;
      serPinOe <= `PORT_BYTE_RESET;
      serPinHighSideOff <= `PORT_BYTE_RESET;
      serPinPullup <= `PORT_BYTE_RESET;
      serPinReduced <= `CTRL_BIT_RESET;
      serFuncIn <= `PORT_BYTE_RESET;
      serDataIn <= `PORT_BYTE_RESET;
      timerPinOut <= `PORT_BYTE_RESET;
      timerPinOe <= `PORT_BYTE_RESET;
      timerPinPullup <= `PORT_BYTE_RESET;
      timerFuncIn <= `PORT_BYTE_RESET;
      timerDataIn <= `PORT_BYTE_RESET;
    end else if (clkEnable) begin
      // tx level passed straight, 0 dominant
      canTxPinOut <= canTxFromCtrl;
      twPinOut <= next_twPinOut;
      twPinOe <= next_twPinOe;
      twPinPullup <= (~next_twPinOe & {WIDTH{twPullupEnable}}) |
        `TW_ALWAYS_PU_MASK;
      twSclIn <= twSync[`TW_SCL_BIT];
      twSdaIn <= twSync[`TW_SDA_BIT];
      twDataIn <= twSync;

      analogADataIn <= convAPowerUp ? `PORT_BYTE_RESET : anASync;
      analogBDataIn <= convBPowerUp ? `PORT_BYTE_RESET : anBSync;

      pwmPinOut <= next_pwmPinOut;
      pwmPinOe <= next_pwmPinOe;
      pwmPinPullup <= ~next_pwmPinOe & {PWM_CH{pwmPullupEnable}};
      pwmDataIn <= pwmSync;

      serPinOut <= next_serPinOut;
      serPinOe <= next_serPinOe;
      serPinHighSideOff <= ({WIDTH{serialLowWireOr}} & `SER_LOW_MASK) |
        ({WIDTH{spiWireOr}} & `SER_HIGH_MASK);
      serPinPullup <= next_serPinPullup;
      serPinReduced <= serialReducedDrive;
      serFuncIn <= serSync;
      serDataIn <= serSync;

      timerPinOut <= next_timerPinOut;
      timerPinOe <= next_timerPinOe;
      timerPinPullup <= ~next_timerPinOe & {WIDTH{timerPullupEnable}};
      timerFuncIn <= tmSync;
      timerDataIn <= tmSync;
    end
  end

  // analog ports have no output controls
endmodule // shared_port_pins
`default_nettype wire

// ---- src/shared_port_pins_regs.vh ----
`ifndef SHARED_PORT_PINS_REGS_VH
`define SHARED_PORT_PINS_REGS_VH
`define CAN_RX_BIT 0
`define CAN_TX_BIT 1
`define CAN_RECESSIVE 1'h1
`define TW_SCL_BIT 7
`define TW_SDA_BIT 6
`define TW_ALWAYS_PU_MASK 8'h3f
`define SER_LOW_MASK 8'h0f
`define SER_HIGH_MASK 8'hf0
`define PORT_BYTE_RESET 8'h00
`define PWM_CHANNELS 4
`define PWM_RESET 4'h0
`define CTRL_BIT_RESET 1'h0
`define TW_LINE_IDLE 1'h1
`define TW_LSB_ONE 8'h01
`endif

// ---- tb/shared_port_pins_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module shared_port_pins_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEnable,
  input wire logic twDirWrite,
  input wire logic convAPowerUp,
  input wire logic serialLowWireOr,
  input wire logic spiWireOr,
  input wire logic [2:0] canTxFromCtrl,
  input wire logic [2:0] canTxPinOut,
  input wire logic [7:0] twDirWrData,
  input wire logic [7:0] twportDirection,
  input wire logic [7:0] twPinOut,
  input wire logic [7:0] twPinPullup,
  input wire logic [7:0] analogADataIn,
  input wire logic [7:0] serPinOe,
  input wire logic [7:0] serPinPullup,
  input wire logic [7:0] serPinHighSideOff
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  AST_CAN_TX: assert property (clkEnable |=> canTxPinOut == $past(canTxFromCtrl))
    else $error("can tx level");
  AST_TW_OPEN_DRAIN: assert property (twPinOut == 8'h00)
    else $error("two-wire drives high");
  AST_TW_LOW_PULL: assert property (twPinPullup[5:0] == 6'h3f)
    else $error("two-wire low pull-ups off");
  AST_TW_DIR: assert property (twDirWrite && clkEnable |=> twportDirection == $past(twDirWrData))
    else $error("two-wire direction load");
  AST_ANALOG_OFF: assert property ((convAPowerUp && clkEnable) [*4] |-> analogADataIn == 8'h00)
    else $error("analog data while powered");
  AST_SER_LOW: assert property (clkEnable |=> serPinHighSideOff[3:0] == {4{$past(serialLowWireOr)}})
    else $error("serial low high-side");
  AST_SER_HIGH: assert property (clkEnable |=> serPinHighSideOff[7:4] == {4{$past(spiWireOr)}})
    else $error("serial high high-side");
  AST_SER_PULL: assert property ((serPinPullup & serPinOe) == 8'h00)
    else $error("pull-up on driven serial pin");
  cover property (twDirWrite);
  cover property (convAPowerUp [*4]);
  cover property (spiWireOr && !serialLowWireOr);
  cover property (!clkEnable);
endmodule // shared_port_pins_props
bind shared_port_pins shared_port_pins_props i_shared_port_pins_props (.*);
`default_nettype wire

// ---- tb/board_pins.sv ----
`timescale 1ns/1ps
`default_nettype none
module board_pins (
  input wire logic [2:0] canTxPinOut,
  output logic [2:0] canRxPinIn,
  input wire logic [7:0] twPinOe,
  input wire logic [7:0] extLow,
  output logic [7:0] twPinIn,
  input wire logic [7:0] serPinOut,
  input wire logic [7:0] serPinOe,
  input wire logic [7:0] serPinHighSideOff,
  input wire logic [7:0] serPinPullup,
  input wire logic [7:0] serExt,
  output logic [7:0] serPinIn
);
  assign canRxPinIn = canTxPinOut;
  assign twPinIn = ~(twPinOe | extLow);
  // a one with high side off floats
  wire [7:0] up = serPinOe & serPinOut & ~serPinHighSideOff;
  wire [7:0] down = serPinOe & ~serPinOut;
  assign serPinIn = up | (~down & (serPinPullup | serExt));
endmodule // board_pins
`default_nettype wire

// ---- tb/tb_shared_port_pins.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_shared_port_pins;
  bit clk, clkEnable = 1, reset = 1, twEnable, twSclDriveLow, twSdaDriveLow, twPullupWrData;
  bit twReducedWrData, convAPowerUp, convBPowerUp, pwmPullupWrData, pwmReducedWrData;
  bit serialLowWireOr, spiWireOr, serialReducedDrive, serialPullupEnable, timerFunctionEnable;
  bit pulseAccumEnable, timerPullupWrData, timerReducedWrData;
  bit [5:0] stb;
  bit [2:0] canTxFromCtrl;
  bit [3:0] pwmChannelEnable, pwmChannelOut, pwmDirWrData, pwmDataOut, pwmPinIn;
  bit [7:0] twDirWrData, twDataOut, analogAPinIn, analogBPinIn, serFuncEnable, serFuncOut;
  bit [7:0] serFuncOe, serDir, serDataOut, timerFuncOut, timerFuncOe, timerDirWrData;
  bit [7:0] timerDataOut, timerPinIn, extLow, serExt;
  wire twSclIn, twSdaIn, twPullupEnable, twReducedDrive, pwmPullupEnable, pwmReducedDrive;
  wire serPinReduced, timerPullupEnable, timerReducedDrive;
  wire [2:0] canRxToCtrl, canTxPinOut, canRxPinIn;
  wire [3:0] pwmDataIn, pwmportDirection, pwmPinOut, pwmPinOe, pwmPinPullup;
  wire [7:0] twDataIn, twportDirection, twPinIn, twPinOut, twPinOe, twPinPullup;
  wire [7:0] analogADataIn, analogBDataIn, serFuncIn, serDataIn, serPinIn, serPinOut, serPinOe;
  wire [7:0] serPinHighSideOff, serPinPullup, timerFuncIn, timerDataIn, timerportDirection;
  wire [7:0] timerPinOut, timerPinOe, timerPinPullup;
  int num_errors, n_compared;
  shared_port_pins i_shared_port_pins (.*, .twDirWrite(stb[0]), .twPullDriveWrite(stb[1]),
    .pwmDirWrite(stb[2]), .pwmCtrlWrite(stb[3]), .timerDirWrite(stb[4]), .timerMaskWrite(stb[5]));
  board_pins i_board_pins (.*);
  initial forever #12.5 clk = ~clk;
  initial begin
    #50000;
    num_errors++;
    print_verdict;
  end
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wt;
    repeat (5) @(posedge clk);
    #1;
  endtask
  // one strobe per register, data bit 0 pull-up, bit 1 reduced drive
  task automatic wr(input int r, input logic [7:0] d);
    @(posedge clk);
    stb <= 6'h1 << r;
    {twDirWrData, timerDirWrData, pwmDirWrData} <= {d, d, d[3:0]};
    {twReducedWrData, twPullupWrData, pwmReducedWrData, pwmPullupWrData} <= {d[1:0], d[1:0]};
    {timerReducedWrData, timerPullupWrData} <= d[1:0];
    @(posedge clk);
    stb <= 6'h0;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset <= 0;
    wt;
    chk({twportDirection, timerportDirection, pwmportDirection}, 0);
    chk(twPinPullup, 8'h3f);
    chk({twPullupEnable, twReducedDrive, pwmPullupEnable, pwmReducedDrive}, 0);
    chk({timerPullupEnable, timerReducedDrive}, 0);
    $display("test reset done");
    wr(0, 8'h80);
    wr(1, 8'h03);
    @(posedge clk) {extLow, twDataOut} <= 16'h0501;
    wt;
    chk({twPinOe, twPinPullup, twDataIn}, 24'h807f7a);
    chk({twPullupEnable, twReducedDrive}, 2'h3);
    @(posedge clk) {twEnable, twSdaDriveLow} <= 2'h3;
    wt;
    chk({twPinOe, 6'h0, twSclIn, twSdaIn}, 16'h4002);
    $display("test twowire done");
    @(posedge clk) {canTxFromCtrl, convAPowerUp, analogAPinIn, analogBPinIn} <= 20'hba53c;
    wt;
    chk({canTxPinOut, canRxToCtrl}, 6'h2d);
    chk({analogADataIn, analogBDataIn}, 16'h003c);
    $display("test can analog done");
    wr(2, 8'h03);
    wr(3, 8'h01);
    wr(4, 8'h0f);
    wr(5, 8'h01);
    @(posedge clk) {pwmDataOut, pwmChannelEnable, pwmChannelOut} <= 12'h144;
    {timerDataOut, timerFuncOut, timerFuncOe} <= 24'h0581c1;
    wt;
    chk({pwmPinOut, pwmPinOe, pwmPinPullup}, 12'h578);
    chk({pwmportDirection, pwmPullupEnable, pwmReducedDrive}, 6'he);
    chk({timerPinOut & timerPinOe, timerPinOe, timerPinPullup}, 24'h050ff0);
    for (int i = 1; i < 3; i++) begin
      @(posedge clk) {timerFunctionEnable, pulseAccumEnable} <= i[1:0];
      wt;
      chk({timerPinOut & timerPinOe, timerPinOe}, 16'h81c1);
    end
    $display("test pwm timer done");
    @(posedge clk) {serFuncEnable, serFuncOut, serFuncOe, serDir, serDataOut} <= 40'hf0a0300301;
    {serialPullupEnable, serialLowWireOr, serialReducedDrive, serExt} <= 11'h740;
    wt;
    chk({serPinOut, serPinOe}, 16'ha133);
    chk({serPinHighSideOff, serPinPullup}, 16'h0f0c);
    chk({serPinReduced, serDataIn}, 9'h16c);
    @(posedge clk) {serialLowWireOr, spiWireOr} <= 2'h1;
    wt;
    chk(serPinHighSideOff, 8'hf0);
    $display("test serial done");
    @(posedge clk) {timerPinIn, pwmPinIn, convBPowerUp} <= 13'hb53;
    wt;
    chk({timerDataIn, timerFuncIn, pwmDataIn}, 20'h5a5a9);
    chk(serFuncIn, 8'h4d);
    chk(analogBDataIn, 8'h00);
    @(posedge clk) clkEnable <= 0;
    @(posedge clk) {canTxFromCtrl, twEnable} <= 4'h0;
    wt;
    chk({canTxPinOut, twPinOe}, 11'h540);
    @(posedge clk) clkEnable <= 1;
    wt;
    chk({canTxPinOut, twPinOe}, 11'h080);
    $display("test inputs freeze done");
    print_verdict;
  end
endmodule // tb_shared_port_pins
`default_nettype wire
